//--- hw/asrc_pkg.sv
// constants for the host-side controller of a 4096 x 1 async static ram
// assumes one 100 MHz clock; timings derived as whole clock cycles
package asrc_pkg;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int ADDR_W = 12;
	localparam int WORDS = 4096;
	// slower grade figures, in ns (fast grade is covered by them)
	localparam int T_RC_NS = 45;
	localparam int T_AA_NS = 45;
	localparam int T_CW_NS = 45;
	localparam int T_AW_NS = 45;
	localparam int T_DW_NS = 25;
	localparam int T_DH_NS = 10;
	localparam int T_HZ_NS = 30;
	// least times round up
	localparam int RC_CYC = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int AA_CYC = (T_AA_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int CW_CYC = (T_CW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int DH_CYC = (T_DH_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int HZ_CYC = (T_HZ_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	typedef enum {
		ASRC_IDLE, ASRC_RD, ASRC_WR, ASRC_WHOLD, ASRC_GAP
	} asrc_state_t;
endpackage : asrc_pkg

//--- hw/asrc_timer.sv
// down counter for the controller's pin timings
// assumes same clock and synchronous reset as the controller
module asrc_timer #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// load and status
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] next_count;
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = value;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign done = (count == '0);
endmodule : asrc_timer

//--- hw/asrc_ctrl.sv
// host controller driving a 4096 x 1 async static ram by its pins
// assumes the ram sits on pins at 100 MHz timing; dout is asynchronous
module asrc_ctrl (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// user request
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic [asrc_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic REQ_DATA,
	output logic READY,
	output logic RD_VALID,
	output logic RD_DATA,
	// supply hold-off
	input wire logic LOW_SUPPLY,
	// ram pins
	output logic RAM_CS_N,
	output logic RAM_WE_N,
	output logic [asrc_pkg::ADDR_W-1:0] RAM_ADDR,
	output logic RAM_DIN,
	input wire logic RAM_DOUT
);
	import asrc_pkg::*;
	localparam int SYNC_STAGES = 2;
	localparam int CNT_MAX = (1 << CNT_W) - 1;
	// refuse timings the down counter cannot hold
	if (RC_CYC < 1 || RC_CYC > CNT_MAX || AA_CYC + SYNC_STAGES > CNT_MAX
		|| CW_CYC > CNT_MAX || HZ_CYC > CNT_MAX || DH_CYC > CNT_MAX
		|| WORDS != (1 << ADDR_W)) begin : g_bad_cfg
		$error("asrc_ctrl: timing does not fit counter");
	end
	asrc_state_t state, next_state;
	logic cs_n, next_cs_n, we_n, next_we_n, din, next_din;
	logic [ADDR_W-1:0] addr, next_addr;
	logic ready, next_ready, rd_valid, next_rd_valid, rd_data, next_rd_data;
	logic dout_s1, dout_s2, low_s1, low_s2;
	logic recover, next_recover;
	logic t_load;
	logic [CNT_W-1:0] t_value;
	logic t_done;
	asrc_timer #(.W(CNT_W)) u_timer (
		.clk(CLK),
		.rst(RST),
		.load(t_load),
		.value(t_value),
		.count(),
		.done(t_done)
	);
	// pin synchronisers
	always_ff @(posedge CLK) begin
		if (RST) begin
			dout_s1 <= 1'b0;
			dout_s2 <= 1'b0;
			low_s1 <= 1'b1;
			low_s2 <= 1'b1;
		end else begin
			dout_s1 <= RAM_DOUT;
			dout_s2 <= dout_s1;
			low_s1 <= LOW_SUPPLY;
			low_s2 <= low_s1;
		end
	end
	always_comb begin
		next_state = state;
		next_cs_n = cs_n;
		next_we_n = we_n;
		next_addr = addr;
		next_din = din;
		next_ready = 1'b0;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		next_recover = recover;
		t_load = 1'b0;
		t_value = CNT_ZERO;
		case (state)
			ASRC_IDLE: begin
				if (low_s2) begin
					// deselected in idle while the synchronised low supply lasts; an access already under way runs to its end first
					next_cs_n = 1'b1;
					next_recover = 1'b1;
				end else if (recover) begin
					// one read cycle time after supply returns
					next_recover = 1'b0;
					t_load = 1'b1;
					t_value = CNT_W'(RC_CYC);
					next_state = ASRC_GAP;
				end else if (REQ && ready) begin
					// address and select change on the same edge
					next_addr = REQ_ADDR;
					next_din = REQ_DATA;
					next_cs_n = 1'b0;
					t_load = 1'b1;
					if (REQ_WRITE) begin
						next_we_n = 1'b0;
						t_value = CNT_W'(CW_CYC);
						next_state = ASRC_WR;
					end else begin
						next_we_n = 1'b1;
						// extra two for the data synchroniser
						t_value = CNT_W'(AA_CYC + SYNC_STAGES);
						next_state = ASRC_RD;
					end
				end else begin
					next_ready = 1'b1;
				end
			end
			ASRC_RD: begin
				if (t_done) begin
					next_rd_data = dout_s2;
					next_rd_valid = 1'b1;
					next_cs_n = 1'b1;
					t_load = 1'b1;
					t_value = CNT_W'(HZ_CYC);
					next_state = ASRC_GAP;
				end
			end
			ASRC_WR: begin
				if (t_done) begin
					// strobe and select rise together
					next_we_n = 1'b1;
					next_cs_n = 1'b1;
					t_load = 1'b1;
					t_value = CNT_W'(DH_CYC);
					next_state = ASRC_WHOLD;
				end
			end
			ASRC_WHOLD: begin
				if (t_done) begin
					next_state = ASRC_IDLE;
					next_ready = !low_s2;
				end
			end
			ASRC_GAP: begin
				if (t_done) begin
					next_state = ASRC_IDLE;
					next_ready = !low_s2;
				end
			end
			default: begin
				next_state = ASRC_IDLE;
				next_cs_n = 1'b1;
				next_we_n = 1'b1;
			end
		endcase
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ASRC_IDLE;
			cs_n <= 1'b1;
			we_n <= 1'b1;
			addr <= '0;
			din <= 1'b0;
			ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 1'b0;
			recover <= 1'b0;
		end else begin
			state <= next_state;
			cs_n <= next_cs_n;
			we_n <= next_we_n;
			addr <= next_addr;
			din <= next_din;
			ready <= next_ready;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			recover <= next_recover;
		end
	end
	assign RAM_CS_N = cs_n;
	assign RAM_WE_N = we_n;
	assign RAM_ADDR = addr;
	assign RAM_DIN = din;
	assign READY = ready;
	assign RD_VALID = rd_valid;
	assign RD_DATA = rd_data;
endmodule : asrc_ctrl

//--- tb/asrc_ram_model.sv
// behavioural 4096 x 1 ram on the controller's pins
// assumes the bench resolves the floating output to a level
module asrc_ram_model (
	// ram pins
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic [asrc_pkg::ADDR_W-1:0] addr,
	input wire logic din,
	output logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	import asrc_pkg::*;
	logic mem [0:WORDS-1];
	logic wr_open = 1'b0;
	initial dout = 1'b0;
	// bit stored when the select and strobe overlap ends
	always @(cs_n, we_n) begin
		if (!cs_n && !we_n) begin
			wr_open = 1'b1;
		end else if (wr_open) begin
			mem[addr] = din;
			wr_open = 1'b0;
		end
	end
	// in a read old value kept, new one after access time; otherwise inverted after 20
	always @(cs_n, we_n, addr) begin
		if (!cs_n && we_n) dout <= #45 mem[addr];
		else dout <= #20 ~dout;
	end
endmodule : asrc_ram_model

//--- tb/asrc_checker.sv
// pin timing checks for the ram controller
// assumes binding onto asrc_ctrl, one clock
module asrc_checker (
	// watched ports
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic [asrc_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic REQ_DATA,
	input wire logic READY,
	input wire logic RD_VALID,
	input wire logic LOW_SUPPLY,
	input wire logic RAM_CS_N,
	input wire logic RAM_WE_N,
	input wire logic [asrc_pkg::ADDR_W-1:0] RAM_ADDR,
	input wire logic RAM_DIN
);
	import asrc_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire rd_take = REQ && READY && !REQ_WRITE;
	wire wr_take = REQ && READY && REQ_WRITE;
	AST_RD_WE: assert property (rd_take |=> RAM_WE_N[*8])
		else $error("strobe low in read");
	AST_RD_ADDR: assert property (rd_take |=> !RAM_CS_N &&
		RAM_ADDR == $past(REQ_ADDR)) else $error("read address late");
	AST_RD_HOLD: assert property ($fell(RAM_CS_N) && RAM_WE_N |=>
		(!RAM_CS_N && $stable(RAM_ADDR))[*7]) else $error("read short");
	AST_RD_DONE: assert property (rd_take |-> ##9 RD_VALID && RAM_CS_N)
		else $error("read result late");
	AST_WR_SET: assert property (wr_take |=> !RAM_WE_N &&
		RAM_DIN == $past(REQ_DATA)) else $error("write data wrong");
	AST_WR_CS: assert property ($fell(RAM_WE_N) |->
		!RAM_CS_N[*6] ##1 RAM_CS_N && RAM_WE_N) else $error("write width");
	AST_WR_HOLD: assert property ($rose(RAM_WE_N) |=>
		$stable(RAM_DIN) && $stable(RAM_ADDR)) else $error("no data hold");
	AST_ADDR_FIX: assert property (!RAM_WE_N && !$past(RAM_WE_N) |->
		$stable(RAM_ADDR)) else $error("address moved in write");
	AST_SUPPLY: assert property (LOW_SUPPLY[*4] |-> RAM_CS_N && !READY)
		else $error("selected at low supply");
	COV_RD: cover property (rd_take ##9 RD_VALID);
	COV_WR: cover property (wr_take);
	COV_SUP: cover property (LOW_SUPPLY[*4]);
endmodule : asrc_checker
bind asrc_ctrl asrc_checker u_chk (
	.CLK(CLK),
	.RST(RST),
	.REQ(REQ),
	.REQ_WRITE(REQ_WRITE),
	.REQ_ADDR(REQ_ADDR),
	.REQ_DATA(REQ_DATA),
	.READY(READY),
	.RD_VALID(RD_VALID),
	.LOW_SUPPLY(LOW_SUPPLY),
	.RAM_CS_N(RAM_CS_N),
	.RAM_WE_N(RAM_WE_N),
	.RAM_ADDR(RAM_ADDR),
	.RAM_DIN(RAM_DIN)
);

//--- tb/testbench.sv
// self-checking bench for the ram controller
// assumes asrc_ctrl, the ram model and the bound checker
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import asrc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, req_write = 1'b0;
	logic req_data = 1'b0, low_supply = 1'b0;
	logic [ADDR_W-1:0] req_addr = 12'h000;
	logic [ADDR_W-1:0] addr;
	logic ready, rd_valid, rd_data, cs_n, we_n, din, dout;
	int n_mismatch = 0;
	int cmp_count = 0;
	asrc_ctrl DUT (.CLK(clk), .RST(rst), .REQ(req), .REQ_WRITE(req_write),
		.REQ_ADDR(req_addr), .REQ_DATA(req_data), .READY(ready),
		.RD_VALID(rd_valid), .RD_DATA(rd_data), .LOW_SUPPLY(low_supply),
		.RAM_CS_N(cs_n), .RAM_WE_N(we_n), .RAM_ADDR(addr), .RAM_DIN(din),
		.RAM_DOUT(dout));
	asrc_ram_model u_ram (.cs_n(cs_n), .we_n(we_n), .addr(addr), .din(din),
		.dout(dout));
	always #5 clk = ~clk;
	task final_report;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task chk(input string nm, input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch %s exp %b got %b", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk
	task op(input logic w, input logic [ADDR_W-1:0] a, input logic d);
		int i;
		for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk) #1;
		chk("ready", ready, 1'b1);
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_data = d;
		@(posedge clk) #1;
		req = 1'b0;
		for (i = 0; i < 20 && !w && rd_valid !== 1'b1; i++) @(posedge clk) #1;
		if (!w) chk("rd_valid", rd_valid, 1'b1);
	endtask : op
	task t_rw;
		for (int k = 0; k < 4; k++) begin
			op(1'b1, k[0] ? 12'hfff : 12'h000, k[1]);
			op(1'b0, k[0] ? 12'hfff : 12'h000, 1'b0);
			chk("rd_data", rd_data, k[1]);
		end
	endtask : t_rw
	task t_refuse;
		op(1'b1, 12'h555, 1'b1);
		@(posedge clk) #1;
		req = 1'b1;
		req_addr = 12'haaa;
		req_data = 1'b0;
		@(posedge clk) #1;
		req = 1'b0;
		chk("ready", ready, 1'b0);
		cmp_count++;
		if (addr !== 12'h555) begin
			$display("mismatch ram_addr exp %h got %h", 12'h555, addr);
			n_mismatch++;
		end
		op(1'b0, 12'h555, 1'b0);
		chk("rd_data", rd_data, 1'b1);
	endtask : t_refuse
	task t_supply;
		low_supply = 1'b1;
		repeat (6) @(posedge clk) #1;
		chk("cs_n", cs_n, 1'b1);
		chk("ready", ready, 1'b0);
		low_supply = 1'b0;
		// no request taken within one read cycle of supply return
		repeat (RC_CYC) @(posedge clk) #1;
		chk("ready", ready, 1'b0);
		op(1'b0, 12'h555, 1'b0);
		chk("rd_data", rd_data, 1'b1);
	endtask : t_supply
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		t_rw;
		t_refuse;
		t_supply;
		final_report;
	end
	initial begin
		#20000;
		n_mismatch++;
		final_report;
	end
endmodule : testbench
